//--- hdl/cde_exec.v
/*
  execution of the complement-file and decrement-file instructions.
  holds the 32-entry file and the working accumulator. assumes the
  core presents one decoded instruction per cycle with insn_valid,
  on core_clk which is the instruction-cycle clock.
*/
`timescale 1ns/1ps
`include "cde_regs.vh"


module cde_exec #(
  parameter DATA_W = `CDE_DATA_W,
  parameter ADDR_W = `CDE_ADDR_W
) (
  input wire core_clk,
  input wire rst,
  input wire insn_valid,
  input wire [`CDE_INSN_W-1:0] insn_word,
  output reg [DATA_W-1:0] acc_reg,
  output reg zero_flag_reg,
  output reg [DATA_W-1:0] result_reg,
  output reg done_reg
);

  localparam DEPTH = 1 << ADDR_W;

  reg [DATA_W-1:0] file_mem [0:DEPTH-1];
  wire [ADDR_W-1:0] faddr;
  wire dest_sel;
  wire [`CDE_OPC_W-1:0] opcode;
  wire is_complement;
  wire is_decrement;
  wire exec_op;
  wire to_file;
  wire to_acc;
  wire [DATA_W-1:0] operand;
  wire [DATA_W-1:0] alu_result;
  wire alu_zero;
  integer i;

  // ************************************************
  // opcode match, shared by both instructions
  // ************************************************
  function cde_opc_match;
    input valid;
    input [`CDE_OPC_W-1:0] opc;
    input [`CDE_OPC_W-1:0] pattern;
    begin
      cde_opc_match = valid && (opc == pattern);
    end
  endfunction

  // ************************************************
  // decode
  // ************************************************
  assign faddr = insn_word[`CDE_FADDR_MSB:`CDE_FADDR_LSB];
  assign dest_sel = insn_word[`CDE_DEST_BIT];
  assign opcode = insn_word[`CDE_OPC_MSB:`CDE_OPC_LSB];
  assign is_complement = cde_opc_match(insn_valid, opcode, `CDE_OPC_COMPLEMENT);
  assign is_decrement = cde_opc_match(insn_valid, opcode, `CDE_OPC_DECREMENT);
  assign exec_op = is_complement || is_decrement;
  assign to_file = exec_op && (dest_sel == `CDE_DEST_FILE);
  assign to_acc = exec_op && (dest_sel == `CDE_DEST_ACC);
  assign operand = file_mem[faddr];

  cde_alu #(
    .DATA_W(DATA_W)
  ) u_alu (
    .operand(operand),
    .do_complement(is_complement),
    .result(alu_result),
    .result_zero(alu_zero)
  );

  // ************************************************
  // file storage, written back when dest selects it
  // ************************************************
  // cleared on reset: costs flops, but a restart never runs on stale data
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        file_mem[i] <= `CDE_ZERO;
      end
    end else if (to_file) begin
      file_mem[faddr] <= alu_result;
    end
  end

  // ************************************************
  // accumulator, flag and result, one cycle per op
  // ************************************************
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      acc_reg <= `CDE_ACC_RESET;
      zero_flag_reg <= `CDE_FLAG_CLEAR;
      result_reg <= `CDE_ZERO;
      done_reg <= `CDE_FLAG_CLEAR;
    end else begin
      done_reg <= exec_op;
      if (exec_op) begin
        result_reg <= alu_result;
        zero_flag_reg <= alu_zero;
      end
      if (to_acc) begin
        acc_reg <= alu_result;
      end
    end
  end

endmodule // cde_exec

//--- hdl/cde_regs.vh
/*
  constants for the complement / decrement execution block:
  instruction word layout, opcode patterns and widths.
  assumes a 12-bit instruction word and an 8-bit data path.
*/
`ifndef CDE_REGS_VH
`define CDE_REGS_VH

// ************************************************
// instruction word layout
// ************************************************
`define CDE_INSN_W 12
`define CDE_DATA_W 8
`define CDE_ADDR_W 5
`define CDE_FADDR_LSB 0
`define CDE_FADDR_MSB 4
`define CDE_DEST_BIT 5
`define CDE_OPC_LSB 6
`define CDE_OPC_MSB 11
`define CDE_OPC_W 6

// ************************************************
// opcode patterns, bits 11:6
// ************************************************
`define CDE_OPC_COMPLEMENT 6'h09
`define CDE_OPC_DECREMENT 6'h03

// ************************************************
// destination select and constants
// ************************************************
`define CDE_DEST_ACC 1'h0
`define CDE_DEST_FILE 1'h1
`define CDE_ACC_RESET 8'h00
`define CDE_ONE 8'h01
`define CDE_ZERO 8'h00
`define CDE_FLAG_CLEAR 1'h0

`endif

//--- hdl/cde_alu.v
/*
  combinational result unit: complement or decrement of one operand,
  with zero detect. assumes the caller qualifies the select.
*/
`timescale 1ns/1ps
`include "cde_regs.vh"

module cde_alu #(
  parameter DATA_W = `CDE_DATA_W
) (
  input wire [DATA_W-1:0] operand,
  input wire do_complement,
  output wire [DATA_W-1:0] result,
  output wire result_zero
);

  // ************************************************
  // result select
  // ************************************************
  assign result = do_complement ? ~operand : operand - `CDE_ONE;
  assign result_zero = (result == {DATA_W{1'h0}});

endmodule // cde_alu

//--- dv/cde_exec_checker.sv
/* port assertions for cde_exec
   assumes binding below */
`timescale 1ns/1ps
module cde_chk (
  input wire core_clk,
  input wire rst,
  input wire insn_valid,
  input wire [11:0] insn_word,
  input wire [7:0] acc_reg,
  input wire zero_flag_reg,
  input wire [7:0] result_reg,
  input wire done_reg
);
  // ****
  // properties
  // ****
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire op_c = insn_valid && insn_word[11:6] == 6'h09;
  wire op_d = insn_valid && insn_word[11:6] == 6'h03;
  wire op = op_c || op_d;
  // file is hidden, so repeat the op and chain on the last result
  cmp_twice_a: assert property (op_c && insn_word[5] ##1 op_c && $stable(insn_word)
    |=> result_reg == ~$past(result_reg)) else $error("bad complement");
  dec_twice_a: assert property (op_d && insn_word[5] ##1 op_d && $stable(insn_word)
    |=> result_reg == $past(result_reg) - 8'h01) else $error("bad decrement");
  dest_acc_a: assert property (op && !insn_word[5] |=> acc_reg == result_reg)
    else $error("acc not written");
  dest_file_a: assert property (op && insn_word[5] |=> $stable(acc_reg))
    else $error("acc written");
  zero_done_a: assert property (op |=> done_reg && zero_flag_reg == (result_reg == 8'h00))
    else $error("bad zero or done");
  idle_hold_a: assert property (!op |=> !done_reg && $stable(result_reg))
    else $error("idle changed state");
  cover property (op_c ##1 op_c);
  cover property (op_d && insn_word[5]);
  cover property (op ##1 zero_flag_reg);
endmodule // cde_chk
bind cde_exec cde_chk u_chk (.core_clk(core_clk), .rst(rst), .insn_valid(insn_valid),
  .insn_word(insn_word), .acc_reg(acc_reg), .zero_flag_reg(zero_flag_reg),
  .result_reg(result_reg), .done_reg(done_reg));

//--- dv/tb_top.sv
/* random bench for cde_exec with a file model
   assumes file memory starts at zero */
`timescale 1ns/1ps
module tb_top;
  reg core_clk = 0, rst = 1, insn_valid = 0;
  reg [11:0] insn_word = 12'h000;
  wire [7:0] acc_reg, result_reg;
  wire zero_flag_reg, done_reg;
  integer seed = 32'h9622, n_mismatch = 0, total_checks = 0, i, r, acc = 0, res = 0, z = 0, dn;
  integer fm [0:31];
  always #12.5 core_clk = ~core_clk;
  cde_exec u_dut (.core_clk(core_clk), .rst(rst), .insn_valid(insn_valid),
    .insn_word(insn_word), .acc_reg(acc_reg), .zero_flag_reg(zero_flag_reg),
    .result_reg(result_reg), .done_reg(done_reg));
  task chk(input [7:0] seen, input [7:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask
  task test_done;
    if (n_mismatch == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    for (i = 0; i < 32; i = i + 1)
      fm[i] = 0;
    repeat (16) @(negedge core_clk);
    rst = 0;
    repeat (3000) begin
      r = $random(seed);
      // a kept word gives back-to-back repeats on one address
      if (r[3:2] != 0) insn_word = {r[1] ? 6'h09 : r[0] ? 6'h03 : r[9:4], r[15:10]};
      insn_valid = r[16] | r[17];
      @(posedge core_clk);
      dn = insn_valid && (insn_word[11:6] == 6'h09 || insn_word[11:6] == 6'h03);
      if (dn) begin
        res = (insn_word[11:6] == 6'h09 ? ~fm[insn_word[4:0]] : fm[insn_word[4:0]] - 1) & 255;
        z = res == 0;
        if (insn_word[5])
          fm[insn_word[4:0]] = res;
        else
          acc = res;
      end
      @(negedge core_clk);
      chk(result_reg, res);
      chk(acc_reg, acc);
      chk({7'h00, zero_flag_reg}, z);
      chk({7'h00, done_reg}, dn);
    end
    test_done;
  end
  initial begin
    #200000;
    n_mismatch = n_mismatch + 1;
    test_done;
  end
endmodule // tb_top
